// File: design/crc_seq.sv
// cache cycle sequencer: processor start/abort and map read hit/miss with slow cycle
//
// Contract
// - cpu start only when idle, no pending others
// - start request latches hold; hold alone starts
// - abort before lock clears hold, drops cycle
// - locked: no other request until done
// - abort in locked cycle sets abort hold
// - abort hold gives done at T180
// - aborted cycle: no slow cycle, no sync
// - map request synchronised into map pending
// - map pending and idle starts map cycle
// - map address to cache and memory bus
// - index bits 9:2, tag bits 21:10 compare
// - address bit 1 selects odd word
// - hit group word goes to map unit
// - map acknowledge at T30, request then withdrawn
// - read hit: done at T180, map done
// - done drops lock and map cycle together
// - miss: slow start at T180, bus start after skew
// - slow cycle takes data from bus registers
// - memory ack, two words, data ready captured
// - bit 1 selects high bus data word
// - ack and ready inhibit timeout, write block in a map cycle
// - restart after inhibit gives done, map done in a map cycle, sync in a processor cycle
// - access granted permits slow start at T180
`timescale 1ns/1ps
`default_nettype none
module crc_seq
    import crc_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              cpu_start,
    input  wire logic              cpu_abort,
    input  wire logic              cpu_access_granted,
    input  wire crc_req_s          cpu_req,
    input  wire logic              map_request,
    input  wire crc_req_s          map_req,
    input  wire logic              mass_controller_pending,
    input  wire logic              read_pause_write,
    input  wire logic              mem_ack,
    input  wire logic              mem_data_ready,
    input  wire crc_block_s        mem_data,
    output var  logic              cpu_cycle,
    output var  logic              map_cycle,
    output var  logic              cycle_lock,
    output var  logic              map_acknowledge,
    output var  logic              map_done,
    output var  logic [WORD_W-1:0] map_rdata,
    output var  logic              mem_sync,
    output var  logic              slow_cycle,
    output var  logic              mem_start,
    output var  crc_req_s          mem_req,
    output var  logic              hit_group0,
    output var  logic              hit_group1,
    output var  logic              bus_timeout_err
);
    localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);

    crc_state_e          state_ff;
    crc_state_e          nxt_state;
    logic [SEQ_CNT_W-1:0] cnt_ff;
    logic [TO_W-1:0]     to_cnt_ff;
    logic                start_hold_ff;
    logic                abort_hold_ff;
    logic                granted_ff;
    logic                cpu_cycle_ff;
    logic                map_cycle_ff;
    logic                lock_ff;
    logic                ack_seen_ff;
    logic                rdy_seen_ff;
    logic                map_ack_ff;
    logic                map_done_ff;
    logic                mem_sync_ff;
    logic                slow_ff;
    logic                mem_start_ff;
    logic                hit0_ff;
    logic                hit1_ff;
    logic                to_err_ff;
    logic [WORD_W-1:0]   rdata_ff;
    crc_req_s            cur_req_ff;
    crc_block_s          bus_data_ff;
    logic [2:0]          sync_out;
    logic                st_hit0;
    logic                st_hit1;
    logic [WORD_W-1:0]   st_word;
    logic                fill_we;

    crc_in_sync #(.WIDTH(3)) u_sync (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .async_in ({map_request, mem_ack, mem_data_ready}),
        .sync_out (sync_out)
    );

    crc_store u_store (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .req      (cur_req_ff),
        .fill_we  (fill_we),
        .fill_blk (bus_data_ff),
        .hit0     (st_hit0),
        .hit1     (st_hit1),
        .rd_word  (st_word)
    );

    wire map_pending = sync_out[2];
    wire ack_s       = sync_out[1];
    wire rdy_s       = sync_out[0];
    wire hit_any     = st_hit0 | st_hit1;

    wire idle        = (state_ff == ST_IDLE);
    wire locked      = (state_ff == ST_LOCKED);
    wire in_mem      = (state_ff == ST_MEM);
    wire restart_w   = (state_ff == ST_FILL);
    wire map_go      = idle && map_pending && !read_pause_write;
    wire cpu_go      = idle && (start_hold_ff | cpu_start) && !cpu_abort
                       && !read_pause_write && !map_pending && !mass_controller_pending;
    wire at_t30      = locked && (cnt_ff == SEQ_CNT_W'(T30_CYC));
    wire at_t180     = locked && (cnt_ff == SEQ_CNT_W'(T180_CYC));
    wire abort_done  = at_t180 && cpu_cycle_ff && abort_hold_ff;
    wire cpu_slow    = at_t180 && cpu_cycle_ff && !abort_hold_ff && granted_ff;
    wire hit_done    = at_t180 && map_cycle_ff && hit_any;
    wire map_miss    = at_t180 && map_cycle_ff && !hit_any;
    wire slow_go     = cpu_slow | map_miss;
    wire skew_end    = (state_ff == ST_SKEW) && (cnt_ff == SEQ_CNT_W'(SKEW_CYC - 1));
    wire resp_ok     = in_mem && ack_seen_ff && rdy_seen_ff;
    wire timeout_w   = in_mem && !resp_ok && (to_cnt_ff == TO_W'(TIMEOUT_CYCLES - 1));
    wire done_w      = abort_done | hit_done | restart_w | timeout_w;
    assign fill_we   = restart_w && map_cycle_ff;
    wire abort_lock  = cpu_abort && cpu_cycle_ff && locked;
    wire hold_clr    = (cpu_abort && !lock_ff) | abort_lock | cpu_slow;
    wire nxt_hold    = cpu_start | (start_hold_ff & !hold_clr);
    wire capture     = in_mem && rdy_s && !rdy_seen_ff;
    wire [WORD_W-1:0] slow_word = cur_req_ff.addr[WSEL_BIT] ? bus_data_ff.hi : bus_data_ff.lo;
    wire [WORD_W-1:0] nxt_rdata = slow_ff ? slow_word : st_word;
    wire crc_req_s    sel_req   = map_go ? map_req : cpu_req;
    wire [SEQ_CNT_W-1:0] nxt_cnt = (nxt_state != state_ff) ? '0 :
                                   (cnt_ff == SEQ_CNT_W'(T180_CYC)) ? cnt_ff : cnt_ff + 1'b1;

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:   if (map_go || cpu_go) nxt_state = ST_LOCKED;
            ST_LOCKED: if (done_w) nxt_state = ST_IDLE;
                       else if (slow_go) nxt_state = ST_SKEW;
            ST_SKEW:   if (skew_end) nxt_state = ST_MEM;
            ST_MEM:    if (resp_ok) nxt_state = ST_FILL;
                       else if (timeout_w) nxt_state = ST_IDLE;
            ST_FILL:   nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff      <= ST_IDLE;
            cnt_ff        <= '0;
            to_cnt_ff     <= '0;
            start_hold_ff <= 1'b0;
            cur_req_ff    <= '0;
        end
        else
        begin
            state_ff      <= nxt_state;
            cnt_ff        <= nxt_cnt;
            to_cnt_ff     <= in_mem ? to_cnt_ff + 1'b1 : '0;
            start_hold_ff <= nxt_hold;
            if (map_go || cpu_go)
                cur_req_ff <= sel_req;
        end
    end

    // cycle flags: all cleared together by done
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lock_ff       <= 1'b0;
            cpu_cycle_ff  <= 1'b0;
            map_cycle_ff  <= 1'b0;
            abort_hold_ff <= 1'b0;
            granted_ff    <= 1'b0;
            slow_ff       <= 1'b0;
        end
        else
        begin
            lock_ff       <= done_w ? 1'b0 : (lock_ff | map_go | cpu_go);
            cpu_cycle_ff  <= done_w ? 1'b0 : (cpu_cycle_ff | cpu_go);
            map_cycle_ff  <= done_w ? 1'b0 : (map_cycle_ff | map_go);
            abort_hold_ff <= done_w ? 1'b0 : (abort_hold_ff | abort_lock);
            granted_ff    <= done_w ? 1'b0 : (granted_ff | (cpu_access_granted && cpu_cycle_ff));
            slow_ff       <= done_w ? 1'b0 : (slow_ff | slow_go);
        end
    end

    // main memory bus side
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_seen_ff  <= 1'b0;
            rdy_seen_ff  <= 1'b0;
            mem_start_ff <= 1'b0;
            bus_data_ff  <= '0;
            to_err_ff    <= 1'b0;
        end
        else
        begin
            ack_seen_ff  <= in_mem && (ack_seen_ff | ack_s);
            rdy_seen_ff  <= in_mem && (rdy_seen_ff | rdy_s);
            mem_start_ff <= skew_end | (mem_start_ff && in_mem && !ack_s && !ack_seen_ff);
            if (capture)
                bus_data_ff <= mem_data;
            to_err_ff    <= timeout_w | (to_err_ff && !(map_go || cpu_go));
        end
    end

    // answers toward processor and map unit
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            map_ack_ff  <= 1'b0;
            map_done_ff <= 1'b0;
            mem_sync_ff <= 1'b0;
            rdata_ff    <= '0;
            hit0_ff     <= 1'b0;
            hit1_ff     <= 1'b0;
        end
        else
        begin
            map_ack_ff  <= at_t30 && map_cycle_ff;
            map_done_ff <= done_w && map_cycle_ff;
            mem_sync_ff <= restart_w && cpu_cycle_ff;
            if (done_w && map_cycle_ff)
                rdata_ff <= nxt_rdata;
            hit0_ff     <= lock_ff && st_hit0;
            hit1_ff     <= lock_ff && st_hit1;
        end
    end

    assign cpu_cycle       = cpu_cycle_ff;
    assign map_cycle       = map_cycle_ff;
    assign cycle_lock      = lock_ff;
    assign map_acknowledge = map_ack_ff;
    assign map_done        = map_done_ff;
    assign map_rdata       = rdata_ff;
    assign mem_sync        = mem_sync_ff;
    assign slow_cycle      = slow_ff;
    assign mem_start       = mem_start_ff;
    assign mem_req         = cur_req_ff;
    assign hit_group0      = hit0_ff;
    assign hit_group1      = hit1_ff;
    assign bus_timeout_err = to_err_ff;

    a_ack_at_t30: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(map_cycle_ff) |-> !map_ack_ff [*8] ##1 !map_ack_ff ##1 map_ack_ff)
        else $error("map acknowledge not at T30");
    a_hit_done_t180: assert property (@(posedge mclk) disable iff (!rst_b)
        ($rose(map_cycle_ff) ##45 hit_any) |=> map_done_ff && !lock_ff && !map_cycle_ff)
        else $error("read hit did not finish at T180");
    a_abort_done: assert property (@(posedge mclk) disable iff (!rst_b)
        (cpu_cycle_ff && abort_hold_ff && cnt_ff == 6'd45 && locked) |=> !lock_ff && !cpu_cycle_ff)
        else $error("aborted cycle not ended at T180");
    a_abort_no_slow: assert property (@(posedge mclk) disable iff (!rst_b)
        (cpu_cycle_ff && abort_hold_ff) |-> !slow_ff && !mem_sync_ff && !mem_start_ff)
        else $error("aborted cycle started memory activity");
    a_lock_excl: assert property (@(posedge mclk) disable iff (!rst_b)
        lock_ff |=> !(cpu_cycle_ff && map_cycle_ff) && ($stable(cur_req_ff) || !lock_ff))
        else $error("second request taken while locked");
    a_cpu_blocked: assert property (@(posedge mclk) disable iff (!rst_b)
        (idle && (map_pending || mass_controller_pending || read_pause_write)) |=> !cpu_cycle_ff)
        else $error("processor cycle started while blocked");
    a_pre_abort_drop: assert property (@(posedge mclk) disable iff (!rst_b)
        (cpu_abort && !cpu_start && !lock_ff) |=> !start_hold_ff && !cpu_cycle_ff)
        else $error("abort before lock did not drop cycle");
    a_hold_starts: assert property (@(posedge mclk) disable iff (!rst_b)
        (start_hold_ff && cpu_go) |=> cpu_cycle_ff && lock_ff)
        else $error("held start did not begin cycle");
    a_skew_start: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(slow_ff) |-> !mem_start_ff [*8] ##18 mem_start_ff)
        else $error("bus start not after skew delay");
    a_timeout_end: assert property (@(posedge mclk) disable iff (!rst_b)
        timeout_w |=> to_err_ff && !lock_ff)
        else $error("timeout did not end cycle");
    a_map_start: assert property (@(posedge mclk) disable iff (!rst_b)
        map_go |=> map_cycle_ff && lock_ff && !cpu_cycle_ff)
        else $error("map cycle not started from pending request");
    a_miss_restart: assert property (@(posedge mclk) disable iff (!rst_b)
        (restart_w && map_cycle_ff) |=> map_done_ff && !lock_ff && (rdata_ff == $past(slow_word)))
        else $error("miss restart did not return bus word");
    a_grant_clear: assert property (@(posedge mclk) disable iff (!rst_b)
        (cpu_slow && !cpu_start) |=> !start_hold_ff && slow_ff)
        else $error("granted cycle did not clear start hold");

endmodule : crc_seq
`default_nettype wire

// File: design/crc_pkg.sv
// constants, carriers and state type shared by the cache request cycle sequencer
package crc_pkg;

    localparam int PA_W          = 22;
    localparam int WORD_W        = 18;
    localparam int OP_W          = 2;
    localparam int IDX_LO        = 2;
    localparam int IDX_HI        = 9;
    localparam int TAG_LO        = 10;
    localparam int TAG_HI        = 21;
    localparam int WSEL_BIT      = 1;
    localparam int IDX_W         = IDX_HI - IDX_LO + 1;
    localparam int TAG_W         = TAG_HI - TAG_LO + 1;
    localparam int GROUPS        = 2;

    localparam int CLK_PERIOD_NS = 4;
    localparam int T30_NS        = 30;
    localparam int T180_NS       = 180;
    localparam int SKEW_NS       = 100;
    localparam int TIMEOUT_NS    = 8000;
    localparam int T30_CYC       = (T30_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T180_CYC      = (T180_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SKEW_CYC      = (SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMEOUT_CYC   = TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int SEQ_CNT_W     = 6;

    typedef struct packed {
        logic [PA_W-1:0] addr;
        logic [OP_W-1:0] op;
    } crc_req_s;

    typedef struct packed {
        logic [WORD_W-1:0] hi;
        logic [WORD_W-1:0] lo;
    } crc_block_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOCKED,
        ST_SKEW,
        ST_MEM,
        ST_FILL
    } crc_state_e;

endpackage : crc_pkg

// File: design/crc_in_sync.sv
// three-stage input synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module crc_in_sync
#(
    parameter int WIDTH = 3
)
(
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;

    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        always_ff @(posedge mclk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                s1_ff[i]    <= 1'b0;
                s2_ff[i]    <= 1'b0;
                s3_ff[i]    <= 1'b0;
                sync_out[i] <= 1'b0;
            end
            else
            begin
                s1_ff[i] <= async_in[i];
                s2_ff[i] <= s1_ff[i];
                s3_ff[i] <= s2_ff[i];
                if (s2_ff[i] == s3_ff[i])
                    sync_out[i] <= s3_ff[i];
            end
        end
    end

endmodule : crc_in_sync
`default_nettype wire

// File: design/crc_store.sv
// two-group tag store and data store with hit detection and block fill
`timescale 1ns/1ps
`default_nettype none
module crc_store
    import crc_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire crc_req_s          req,
    input  wire logic              fill_we,
    input  wire crc_block_s        fill_blk,
    output var  logic              hit0,
    output var  logic              hit1,
    output var  logic [WORD_W-1:0] rd_word
);
    localparam int DEPTH = 1 << IDX_W;

    logic [TAG_W-1:0]  tag_ff   [GROUPS][DEPTH];
    logic              valid_ff [GROUPS][DEPTH];
    crc_block_s        blk_ff   [GROUPS][DEPTH];
    logic              rr_ff;
    logic [GROUPS-1:0] hit;
    logic [WORD_W-1:0] word [GROUPS];
    wire  [IDX_W-1:0]  idx       = req.addr[IDX_HI:IDX_LO];
    wire  [TAG_W-1:0]  tag       = req.addr[TAG_HI:TAG_LO];
    wire               odd       = req.addr[WSEL_BIT];
    // refill an empty group first, otherwise alternate
    wire               fill_grp  = !valid_ff[0][idx] ? 1'b0 : (!valid_ff[1][idx] ? 1'b1 : rr_ff);

    for (genvar g = 0; g < GROUPS; g++)
    begin : g_grp
        assign hit[g]  = valid_ff[g][idx] && (tag_ff[g][idx] == tag);
        assign word[g] = odd ? blk_ff[g][idx].hi : blk_ff[g][idx].lo;
        always_ff @(posedge mclk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                for (int e = 0; e < DEPTH; e++)
                begin
                    tag_ff[g][e]   <= '0;
                    valid_ff[g][e] <= 1'b0;
                    blk_ff[g][e]   <= '0;
                end
            end
            else if (fill_we && (fill_grp == 1'(g)))
            begin
                tag_ff[g][idx]   <= tag;
                valid_ff[g][idx] <= 1'b1;
                blk_ff[g][idx]   <= fill_blk;
            end
        end
    end

    assign hit0    = hit[0];
    assign hit1    = hit[1];
    assign rd_word = hit[1] ? word[1] : word[0];

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rr_ff <= 1'b0;
        else if (fill_we)
            rr_ff <= !fill_grp;
    end

endmodule : crc_store
`default_nettype wire

// File: verif/crc_mem_model.sv
// main memory partner: answers a slow cycle with ack, then a two-word block and data ready
`timescale 1ns/1ps
`default_nettype none
module crc_mem_model
    import crc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       mem_start,
    input  wire crc_req_s   mem_req,
    input  wire logic       cycle_lock,
    input  wire logic [7:0] dly,
    input  wire logic       mute,
    output var  logic       mem_ack,
    output var  logic       mem_data_ready,
    output var  crc_block_s mem_data
);
    logic             busy;
    logic [7:0]       cnt;
    logic [WORD_W-1:0] wa;
    assign wa = mem_req.addr[19:2];

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busy <= 1'b0;
            cnt <= 8'h00;
            mem_ack <= 1'b0;
            mem_data_ready <= 1'b0;
            mem_data <= '0;
        end
        else
        begin
            if (!cycle_lock)
            begin
                busy <= 1'b0;
                mem_ack <= 1'b0;
                mem_data_ready <= 1'b0;
            end
            else if (mem_start && !busy && !mute)
            begin
                busy <= 1'b1;
                cnt <= dly;
            end
            else if (busy && cnt != 8'h00)
                cnt <= cnt - 8'h01;
            else if (busy && !mem_ack)
            begin
                mem_ack <= 1'b1;
                cnt <= dly;
            end
            else if (busy && !mem_data_ready)
                mem_data_ready <= 1'b1;
            // data lines change every cycle unless a block is being returned
            if (!mem_ack || !busy)
                mem_data <= ~mem_data;
            else if (!mem_data_ready)
                mem_data <= {wa ^ 18'h3c3c3, wa ^ 18'h0f0f0};
        end
    end
endmodule : crc_mem_model
`default_nettype wire

// File: verif/tb_cache_request_cycle_control.sv
// self-checking testbench of the cache cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_cache_request_cycle_control;
    import crc_pkg::*;
    logic mclk, rst_b, cpu_start, cpu_abort, cpu_access_granted, map_request;
    logic mass_controller_pending, read_pause_write, mem_ack, mem_data_ready, mute;
    logic cpu_cycle, map_cycle, cycle_lock, map_acknowledge, map_done, mem_sync;
    logic slow_cycle, mem_start, hit_group0, hit_group1, bus_timeout_err, slow, ms, hg;
    logic [7:0]        dly;
    logic [WORD_W-1:0] map_rdata, rd;
    crc_req_s          cpu_req, map_req, mem_req;
    crc_block_s        mem_data;
    int                errors, n_checks, nack, ndone, nslow, nstart;
    bit                seen [logic [19:0]];

    crc_seq #(.TIMEOUT_CYCLES(50)) uut (.mclk, .rst_b, .cpu_start, .cpu_abort, .cpu_access_granted,
        .cpu_req, .map_request, .map_req, .mass_controller_pending, .read_pause_write, .mem_ack,
        .mem_data_ready, .mem_data, .cpu_cycle, .map_cycle, .cycle_lock, .map_acknowledge, .map_done,
        .map_rdata, .mem_sync, .slow_cycle, .mem_start, .mem_req, .hit_group0, .hit_group1,
        .bus_timeout_err);
    crc_mem_model mem (.mclk, .rst_b, .mem_start, .mem_req, .cycle_lock, .dly, .mute, .mem_ack,
        .mem_data_ready, .mem_data);

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(input logic [35:0] seen_v, input logic [35:0] exp);
        n_checks++;
        if (seen_v !== exp)
        begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen_v, exp);
        end
    endtask : check

    task automatic conclude;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    function automatic logic [WORD_W-1:0] exp_word(input logic [PA_W-1:0] a);
        exp_word = a[WSEL_BIT] ? (a[19:2] ^ 18'h3c3c3) : (a[19:2] ^ 18'h0f0f0);
    endfunction : exp_word

    function automatic logic [PA_W-1:0] mk_addr(input logic [7:0] ix);
        mk_addr = {($urandom_range(0, 1) != 0) ? 12'h5a3 : 12'ha5c, ix, 1'($urandom), 1'b0};
    endfunction : mk_addr

    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask : step

    task automatic map_read(input logic [PA_W-1:0] a);
        int g;
        step(8);
        map_req = {a, 2'h0};
        step(1);
        map_request = 1'b1;
        for (g = 0; map_cycle !== 1'b1 && g < 20; g++) step(1);
        nack = -1;
        nslow = -1;
        nstart = -1;
        hg = 1'b0;
        for (ndone = 0; map_done !== 1'b1 && ndone < 3000; ndone++)
        begin
            if (map_acknowledge === 1'b1)
            begin
                nack = ndone;
                map_request = 1'b0;
            end
            if (slow_cycle === 1'b1 && nslow < 0) nslow = ndone;
            if (mem_start === 1'b1 && nstart < 0) nstart = ndone;
            hg |= hit_group0 | hit_group1;
            step(1);
        end
        check(map_done, 1'b1);
        rd = map_rdata;
        check(nack, 9);
        check(mem_req, {a, 2'h0});
        check({cycle_lock, map_cycle}, 2'h0);
    endtask : map_read

    task automatic rd_chk(input logic [PA_W-1:0] a);
        logic h;
        h = seen.exists(a[21:2]);
        map_read(a);
        check(nslow < 0, h);
        if (h)
        begin
            check(ndone, 46);
            check(hg, 1'b1);
        end
        else
        begin
            check(nslow, 46);
            check(hg, 1'b0);
            check(nstart - nslow, 25);
        end
        check(rd, exp_word(a));
        check(bus_timeout_err, 1'b0);
        seen[a[21:2]] = 1'b1;
        $display("map read %h done", a);
    endtask : rd_chk

    task automatic cpu_op(input logic ab);
        int n;
        step(2);
        cpu_req = 24'($urandom);
        cpu_start = 1'b1;
        step(1);
        cpu_start = 1'b0;
        for (n = 0; cpu_cycle !== 1'b1 && n < 20; n++) step(1);
        step(1);
        cpu_abort = ab;
        cpu_access_granted = !ab;
        step(1);
        cpu_abort = 1'b0;
        cpu_access_granted = 1'b0;
        slow = 1'b0;
        ms = 1'b0;
        for (n = 2; cycle_lock === 1'b1 && n < 3000; n++)
        begin
            slow |= slow_cycle;
            ms |= mem_sync;
            step(1);
        end
        ms |= mem_sync;
        check(cycle_lock, 1'b0);
        if (ab) check(n, 46);
        check({slow, ms}, ab ? 2'b00 : 2'b11);
        $display("processor cycle abort=%0d done", ab);
    endtask : cpu_op

    initial
    begin
        #100000;
        errors++;
        $display("ERROR t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
        conclude();
    end

    initial
    begin
        logic [PA_W-1:0] a;
        void'($urandom(32'hbbbdbf74));
        {rst_b, cpu_start, cpu_abort, cpu_access_granted, map_request, mute} = '0;
        {mass_controller_pending, read_pause_write} = '0;
        cpu_req = '0;
        map_req = '0;
        dly = 8'h03;
        step(5);
        check({cpu_cycle, map_cycle, cycle_lock, map_acknowledge, map_done, mem_sync, slow_cycle,
               mem_start, bus_timeout_err}, 9'h000);
        step(2);
        rst_b = 1'b1;
        a = mk_addr(8'h01) | 22'h2;
        rd_chk(a);
        rd_chk(a);
        rd_chk(a ^ 22'h2);
        for (int i = 0; i < 14; i++)
        begin
            dly = 8'($urandom_range(0, 15));
            rd_chk(mk_addr(8'($urandom_range(0, 3))));
        end
        mute = 1'b1;
        map_read(mk_addr(8'h80));
        check(bus_timeout_err, 1'b1);
        mute = 1'b0;
        $display("memory timeout done");
        cpu_op(1'b1);
        cpu_op(1'b0);
        read_pause_write = 1'b1;
        mass_controller_pending = 1'b1;
        cpu_start = 1'b1;
        step(1);
        cpu_start = 1'b0;
        step(4);
        read_pause_write = 1'b0;
        step(4);
        check(cpu_cycle, 1'b0);
        mass_controller_pending = 1'b0;
        step(3);
        check({cpu_cycle, cycle_lock}, 2'b11);
        cpu_abort = 1'b1;
        step(1);
        cpu_abort = 1'b0;
        step(60);
        check(cycle_lock, 1'b0);
        read_pause_write = 1'b1;
        cpu_start = 1'b1;
        step(1);
        cpu_start = 1'b0;
        cpu_abort = 1'b1;
        step(1);
        cpu_abort = 1'b0;
        read_pause_write = 1'b0;
        step(8);
        check(cpu_cycle, 1'b0);
        $display("start hold and early abort done");
        conclude();
    end
endmodule : tb_cache_request_cycle_control
`default_nettype wire
